/* dv/srcf_link_sva.sv */
// checker for the four-wire link between host framer and device
// assumes inputs are the link signals plus the system clock and reset
`timescale 1ns/10ps
module srcf_link_sva (
	input wire logic clk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout
);
	logic sclk_q;
	logic [5:0] cnt_q, cnt_d, ones_q, ones_d;
	logic [7:0] sh_q, sh_d, cmd_q, cmd_d;
	logic rise;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	assign rise = sclk && !sclk_q;
	////////////////////////////////////////////////////////////////
	// rise count, run of ones and command byte of the frame
	always_comb begin
		cnt_d = cnt_q;
		ones_d = ones_q;
		sh_d = sh_q;
		cmd_d = cmd_q;
		if (cs_n) begin
			cnt_d = 6'h00;
			ones_d = 6'h00;
		end else if (rise) begin
			cnt_d = cnt_q + 6'h01;
			ones_d = din ? ones_q + 6'h01 : 6'h00;
			sh_d = {sh_q[6:0], din};
			if (cnt_q == 6'h07) begin
				cmd_d = {sh_q[6:0], din};
			end
		end
	end
	// helper registers
	always_ff @(posedge clk) begin
		sclk_q <= srst ? 1'b0 : sclk;
		cnt_q <= srst ? 6'h00 : cnt_d;
		ones_q <= srst ? 6'h00 : ones_d;
		sh_q <= srst ? 8'h00 : sh_d;
		cmd_q <= srst ? 8'h00 : cmd_d;
	end
	////////////////////////////////////////////////////////////////
	property p_idle_low; cs_n |-> !sclk; endproperty
	a_idle_low: assert property (p_idle_low) else $error("sclk high while idle");
	property p_frame_len; $rose(cs_n) |-> cnt_q == 6'h10 || cnt_q == 6'h20; endproperty
	a_frame_len: assert property (p_frame_len) else $error("bad frame length");
	property p_cmd_msb; $rose(cs_n) && cnt_q == 6'h10 |-> !cmd_q[7]; endproperty
	a_cmd_msb: assert property (p_cmd_msb) else $error("command msb set");
	property p_resync_ones; $rose(cs_n) && cnt_q == 6'h20 |-> ones_q == 6'h20; endproperty
	a_resync_ones: assert property (p_resync_ones) else $error("resync not all ones");
	property p_gap; $rose(cs_n) |=> cs_n; endproperty
	a_gap: assert property (p_gap) else $error("select gap too short");
	property p_dout_idle; cs_n |-> !dout; endproperty
	a_dout_idle: assert property (p_dout_idle) else $error("dout busy while idle");
	property p_din_steady; $changed(din) || $changed(cs_n) |-> !sclk; endproperty
	a_din_steady: assert property (p_din_steady) else $error("din moved, sclk high");
	property p_mode_rd_base;
		rise && cnt_q == 6'h08 && cmd_q[7:3] == 5'h0F |-> cmd_q[2:0] == 3'h0;
	endproperty
	a_mode_rd_base: assert property (p_mode_rd_base) else $error("mode read alias");
	property p_rd_din_low;
		rise && cnt_q >= 6'h08 && cnt_q < 6'h10 && cmd_q[7:6] == 2'h1 |-> !din;
	endproperty
	a_rd_din_low: assert property (p_rd_din_low) else $error("din high in read");
endmodule : srcf_link_sva

/* dv/tb_top.sv */
// testbench: host framer and device joined by the link, random traffic
// assumes the package, interface and both ends are compiled first
`timescale 1ns/10ps
module tb_top;
	import srcf_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0, req_read = 1'b0, resync_req = 1'b0;
	logic [5:0] req_addr = 6'h00;
	logic [7:0] req_wdata = 8'h00;
	logic req_ready, rsp_valid, ain_neg_common, cfg_update, resync_seen;
	logic [7:0] rsp_rdata, cfg_mode, cfg_setup, md;
	logic [2:0] cfg_mode_chan, ain_pos, ain_neg, ch;
	logic [7:0] setup_m [8];
	logic d;
	int err_total = 0, checks_done = 0, cyc = 0, rs_cnt = 0, up_cnt = 0;
	srcf_link_if i_srcf_link_if ();
	srcf_host #(.HALF(4)) i_srcf_host (.clk(clk), .srst(srst), .link(i_srcf_link_if.host),
		.req_valid(req_valid), .req_read(req_read), .req_addr(req_addr),
		.req_wdata(req_wdata), .resync_req(resync_req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	srcf_dev i_srcf_dev (.clk(clk), .srst(srst), .link(i_srcf_link_if.dev),
		.cfg_mode(cfg_mode), .cfg_mode_chan(cfg_mode_chan), .cfg_setup(cfg_setup),
		.ain_pos(ain_pos), .ain_neg(ain_neg), .ain_neg_common(ain_neg_common),
		.cfg_update(cfg_update), .resync_seen(resync_seen));
	srcf_link_sva i_srcf_link_sva (.clk(clk), .srst(srst), .cs_n(i_srcf_link_if.cs_n),
		.sclk(i_srcf_link_if.sclk), .din(i_srcf_link_if.din), .dout(i_srcf_link_if.dout));
	////////////////////////////////////////////////////////////////
	// expected input index of a channel
	function automatic logic [2:0] exp_ain(input logic [2:0] c, input logic df, input logic n);
		return df ? {c[1:0], n} : c;
	endfunction : exp_ain
	// compare and count
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// verdict and end of run
	task finish_test();
		if (err_total == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// one host frame, waits for its end
	task xfer(input logic rd, input logic [5:0] a, input logic [7:0] w, input logic rs);
		int n;
		n = 0;
		req_read <= rd;
		req_addr <= a;
		req_wdata <= w;
		req_valid <= !rs;
		resync_req <= rs;
		@(posedge clk);
		req_valid <= 1'b0;
		resync_req <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n == 400) begin
			err_total++;
			finish_test();
		end
		chk("ready", {7'h00, req_ready}, 8'h01);
	endtask : xfer
	// device outputs at reset values
	task chk_reset();
		chk("mode", cfg_mode, MODE_RESET);
		chk("setup", cfg_setup, SETUP_RESET);
		chk("pos", {5'h00, ain_pos}, 8'h00);
		chk("com", {7'h00, ain_neg_common}, 8'h01);
	endtask : chk_reset
	////////////////////////////////////////////////////////////////
	// clock
	initial begin
		forever #50 clk = ~clk;
	end
	// pulse counters and timeout
	always @(posedge clk) begin
		cyc++;
		if (resync_seen === 1'b1) rs_cnt++;
		if (cfg_update === 1'b1) up_cnt++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		void'($urandom(32'h00A2F6AE));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (8) @(posedge clk);
		chk_reset();
		for (int i = 0; i < 8; i++) begin
			ch = 3'(i);
			d = i[0] ^ i[2];
			setup_m[i] = 8'($urandom);
			setup_m[i][DIFF_BIT] = d;
			md = 8'($urandom);
			xfer(1'b0, {SETUP_BLK, ch}, setup_m[i], 1'b0);
			xfer(1'b0, {MODE_BLK, ch}, md, 1'b0);
			repeat (3) @(posedge clk);
			chk("mode", cfg_mode, md);
			chk("mchan", {5'h00, cfg_mode_chan}, {5'h00, ch});
			chk("setup", cfg_setup, setup_m[i]);
			chk("pos", {5'h00, ain_pos}, {5'h00, exp_ain(ch, d, 1'b0)});
			chk("com", {7'h00, ain_neg_common}, {7'h00, !d});
			if (d) chk("neg", {5'h00, ain_neg}, {5'h00, exp_ain(ch, d, 1'b1)});
			xfer(1'b1, {MODE_BLK, 3'($urandom)}, 8'h00, 1'b0);
			chk("rdmode", rsp_rdata, md);
		end
		chk("upd", up_cnt[7:0], 8'h10);
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, {SETUP_BLK, 3'(i)}, 8'h00, 1'b0);
			chk("rdsetup", rsp_rdata, setup_m[i]);
		end
		xfer(1'b0, 6'h05, 8'hFF, 1'b0);
		xfer(1'b1, 6'h05, 8'h00, 1'b0);
		chk("unmapped", rsp_rdata, 8'h00);
		xfer(1'b0, 6'h00, 8'h00, 1'b1);
		repeat (10) @(posedge clk);
		chk("resync", rs_cnt[7:0], 8'h01);
		chk_reset();
		xfer(1'b1, 6'h2F, 8'h00, 1'b0);
		chk("rdclr", rsp_rdata, SETUP_RESET);
		xfer(1'b0, 6'h38, 8'hA5, 1'b0);
		xfer(1'b1, 6'h38, 8'h00, 1'b0);
		chk("rdafter", rsp_rdata, 8'hA5);
		finish_test();
	end
endmodule : tb_top

/* verilog/srcf_dev.sv */
// device end: command byte interpreter, register store, resync detect
// assumes cs_n and din change only while sclk is low (host guarantees)
// assumes sclk is still whenever the link reset is released
`timescale 1ns/10ps
// Function
// RULE_01: every frame opens with one command byte
// RULE_02: command selects read or write and register
// RULE_03: after reset or access, await new command
// RULE_04: 32 ones with select low resets
// RULE_05: resync resets every register and interface
// RULE_06: host holds din low during reads
// RULE_07: bit7 zero, bit6 read, bits5-0 address
// RULE_08: low three address bits give channel
// RULE_09: mode write alias sets mode channel
// RULE_10: host reads mode only at base
// RULE_11: differential channels 4-7 reuse pairs 0-3
module srcf_dev (
	input wire logic clk,
	input wire logic srst,
	srcf_link_if.dev link,
	output logic [srcf_pkg::BYTE_BITS-1:0] cfg_mode,
	output logic [srcf_pkg::CHAN_BITS-1:0] cfg_mode_chan,
	output logic [srcf_pkg::BYTE_BITS-1:0] cfg_setup,
	output logic [srcf_pkg::CHAN_BITS-1:0] ain_pos,
	output logic [srcf_pkg::CHAN_BITS-1:0] ain_neg,
	output logic ain_neg_common,
	output logic cfg_update,
	output logic resync_seen
);
	import srcf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// link domain state (clocked by sclk, reset by link_rst_q)
	srcf_lst_e st_q, st_d;
	logic [2:0] bit_q, bit_d;
	logic [BYTE_BITS-1:0] sh_q, sh_d;
	logic [BYTE_BITS-1:0] cmd_q, cmd_d;
	logic [BYTE_BITS-1:0] rd_sh_q, rd_sh_d;
	logic dout_q, dout_d;
	logic [5:0] ones_q, ones_d;
	logic rs_tgl_q, rs_tgl_d;
	logic wr_tgl_q, wr_tgl_d;
	logic [BYTE_BITS-1:0] mode_q, mode_d;
	logic [CHAN_BITS-1:0] mchan_q, mchan_d;
	logic [BYTE_BITS-1:0] setup_q [CHANS];
	logic [BYTE_BITS-1:0] setup_d [CHANS];
	logic link_rst_q, link_rst_d;
	logic [BYTE_BITS-1:0] byte_in;
	logic [BYTE_BITS-1:0] rd_val;
	logic [ADDR_BITS-1:0] cmd_addr;

	// byte formed by this edge's bit
	assign byte_in = {sh_q[BYTE_BITS-2:0], link.din};
	assign cmd_addr = cmd_q[ADDR_BITS-1:0];
	assign link.dout = dout_q;

	// register read mux; unmapped addresses read zero
	always_comb begin
		logic [ADDR_BITS-1:0] a;
		a = byte_in[ADDR_BITS-1:0];
		rd_val = '0;
		if (a[5:3] == SETUP_BLK) begin
			rd_val = setup_q[a[CHAN_BITS-1:0]]; // RULE_08
		end else if (a[5:3] == MODE_BLK) begin
			rd_val = mode_q;
		end
	end

	// next state of the serial front end
	always_comb begin
		st_d = st_q;
		bit_d = bit_q + 3'h1;
		sh_d = byte_in;
		cmd_d = cmd_q;
		rd_sh_d = rd_sh_q;
		dout_d = dout_q;
		ones_d = ones_q;
		rs_tgl_d = rs_tgl_q;
		wr_tgl_d = wr_tgl_q;
		mode_d = mode_q;
		mchan_d = mchan_q;
		for (int i = 0; i < CHANS; i++) begin
			setup_d[i] = setup_q[i];
		end
		if (link.cs_n) begin
			// select high: hold everything, edge count and shifter both stop
			bit_d = bit_q;
			sh_d = sh_q;
		end else begin
			// count consecutive ones with select low
			if (!link.din) begin
				ones_d = '0;
			end else if (ones_q != 6'(RESYNC_ONES)) begin
				ones_d = ones_q + 6'h01;
				if (ones_q == 6'(RESYNC_ONES - 1)) begin
					rs_tgl_d = ~rs_tgl_q; // RULE_04
				end
			end
			case (st_q)
				SRCF_CMD: begin
					if (bit_q == 3'(BYTE_BITS - 1)) begin
						cmd_d = byte_in; // RULE_01
						if (byte_in[CMD_RD_BIT]) begin // RULE_07
							st_d = SRCF_RD; // RULE_02
							dout_d = rd_val[BYTE_BITS-1];
							rd_sh_d = {rd_val[BYTE_BITS-2:0], 1'b0};
						end else begin
							st_d = SRCF_WR; // RULE_02
						end
					end
				end
				SRCF_WR: begin
					if (bit_q == 3'(BYTE_BITS - 1)) begin
						st_d = SRCF_CMD; // RULE_03
						wr_tgl_d = ~wr_tgl_q;
						if (cmd_addr[5:3] == SETUP_BLK) begin
							setup_d[cmd_addr[CHAN_BITS-1:0]] = byte_in; // RULE_08
						end else if (cmd_addr[5:3] == MODE_BLK) begin
							mode_d = byte_in;
							mchan_d = cmd_addr[CHAN_BITS-1:0]; // RULE_09
						end
					end
				end
				SRCF_RD: begin
					dout_d = rd_sh_q[BYTE_BITS-1];
					rd_sh_d = {rd_sh_q[BYTE_BITS-2:0], 1'b0};
					if (bit_q == 3'(BYTE_BITS - 1)) begin
						st_d = SRCF_CMD; // RULE_03
						dout_d = 1'b0;
					end
				end
				default: begin
					st_d = SRCF_CMD;
				end
			endcase
		end
	end

	// link registers; the link reset clears the whole interface and store
	always_ff @(posedge link.sclk or posedge link_rst_q) begin
		if (link_rst_q) begin
			st_q <= SRCF_CMD; // RULE_05
			bit_q <= '0;
			sh_q <= '0;
			cmd_q <= '0;
			rd_sh_q <= '0;
			dout_q <= 1'b0;
			ones_q <= '0;
			rs_tgl_q <= 1'b0;
			wr_tgl_q <= 1'b0;
			mode_q <= MODE_RESET; // RULE_05
			mchan_q <= '0;
			for (int i = 0; i < CHANS; i++) begin
				setup_q[i] <= SETUP_RESET; // RULE_05
			end
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			cmd_q <= cmd_d;
			rd_sh_q <= rd_sh_d;
			dout_q <= dout_d;
			ones_q <= ones_d;
			rs_tgl_q <= rs_tgl_d;
			wr_tgl_q <= wr_tgl_d;
			mode_q <= mode_d;
			mchan_q <= mchan_d;
			for (int i = 0; i < CHANS; i++) begin
				setup_q[i] <= setup_d[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// system clock domain: toggle synchronisers and link reset
	logic [2:0] wr_s_q, wr_s_d;
	logic [2:0] rs_s_q, rs_s_d;
	logic wr_seen_q, wr_seen_d;
	logic rs_seen_q, rs_seen_d;
	logic [2:0] hold_q, hold_d;
	logic wr_ev;
	logic rs_ev;

	// an event counts once second and third stages agree
	assign wr_ev = (wr_s_q[1] == wr_s_q[2]) && (wr_s_q[2] != wr_seen_q);
	assign rs_ev = (rs_s_q[1] == rs_s_q[2]) && (rs_s_q[2] != rs_seen_q);

	// reset hold: srst or a detected resync pulls the link reset
	always_comb begin
		wr_s_d = {wr_s_q[1:0], wr_tgl_q};
		rs_s_d = {rs_s_q[1:0], rs_tgl_q};
		wr_seen_d = wr_ev ? wr_s_q[2] : wr_seen_q;
		rs_seen_d = rs_ev ? rs_s_q[2] : rs_seen_q;
		hold_d = hold_q;
		link_rst_d = 1'b0;
		if (rs_ev) begin
			hold_d = 3'(RST_HOLD); // RULE_05
		end else if (hold_q != 3'h0) begin
			hold_d = hold_q - 3'h1;
		end
		if (rs_ev || hold_q != 3'h0) begin
			link_rst_d = 1'b1; // RULE_05
		end
		if (link_rst_q) begin
			// link toggles return to zero; follow them without events
			wr_s_d = '0;
			rs_s_d = '0;
			wr_seen_d = 1'b0;
			rs_seen_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_s_q <= '0;
			rs_s_q <= '0;
			wr_seen_q <= 1'b0;
			rs_seen_q <= 1'b0;
			hold_q <= 3'(RST_HOLD);
			link_rst_q <= 1'b1;
		end else begin
			wr_s_q <= wr_s_d;
			rs_s_q <= rs_s_d;
			wr_seen_q <= wr_seen_d;
			rs_seen_q <= rs_seen_d;
			hold_q <= hold_d;
			link_rst_q <= link_rst_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// user side copy of configuration, taken after each write
	logic [BYTE_BITS-1:0] o_mode_d, o_setup_d;
	logic [CHAN_BITS-1:0] o_mchan_d, o_pos_d, o_neg_d;
	logic o_com_d, o_upd_d, o_rs_d;

	always_comb begin
		logic [BYTE_BITS-1:0] s;
		s = setup_q[mchan_q];
		o_mode_d = cfg_mode;
		o_mchan_d = cfg_mode_chan;
		o_setup_d = cfg_setup;
		o_pos_d = ain_pos;
		o_neg_d = ain_neg;
		o_com_d = ain_neg_common;
		o_upd_d = wr_ev;
		o_rs_d = rs_ev;
		if (rs_ev || link_rst_q) begin
			o_mode_d = MODE_RESET;
			o_mchan_d = '0;
			o_setup_d = SETUP_RESET;
			o_pos_d = '0;
			o_neg_d = '0;
			o_com_d = ~SETUP_RESET[DIFF_BIT];
		end else if (wr_ev) begin
			o_mode_d = mode_q;
			o_mchan_d = mchan_q; // RULE_09
			o_setup_d = s;
			if (s[DIFF_BIT]) begin
				// pair index wraps, channels 4-7 alias 0-3
				o_pos_d = {mchan_q[1:0], 1'b0}; // RULE_11
				o_neg_d = {mchan_q[1:0], 1'b1}; // RULE_11
				o_com_d = 1'b0;
			end else begin
				o_pos_d = mchan_q; // RULE_11
				o_neg_d = '0;
				o_com_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_mode <= MODE_RESET;
			cfg_mode_chan <= '0;
			cfg_setup <= SETUP_RESET;
			ain_pos <= '0;
			ain_neg <= '0;
			ain_neg_common <= ~SETUP_RESET[DIFF_BIT];
			cfg_update <= 1'b0;
			resync_seen <= 1'b0;
		end else begin
			cfg_mode <= o_mode_d;
			cfg_mode_chan <= o_mchan_d;
			cfg_setup <= o_setup_d;
			ain_pos <= o_pos_d;
			ain_neg <= o_neg_d;
			ain_neg_common <= o_com_d;
			cfg_update <= o_upd_d;
			resync_seen <= o_rs_d;
		end
	end
endmodule : srcf_dev

/* verilog/srcf_host.sv */
// host end: frames one command byte plus one data byte, or a resync
// assumes the device samples din on the rising sclk edge
`timescale 1ns/10ps
module srcf_host #(
	parameter int HALF = 4
) (
	input wire logic clk,
	input wire logic srst,
	srcf_link_if.host link,
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic [srcf_pkg::ADDR_BITS-1:0] req_addr,
	input wire logic [srcf_pkg::BYTE_BITS-1:0] req_wdata,
	input wire logic resync_req,
	output logic req_ready,
	output logic rsp_valid,
	output logic [srcf_pkg::BYTE_BITS-1:0] rsp_rdata
);
	import srcf_pkg::*;

	// dout must be seen through the synchroniser before the next rise
	if (HALF < 2) begin : g_chk
		$error("srcf_host: HALF must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////
	srcf_hst_e st_q, st_d;
	logic [7:0] div_q, div_d;
	logic [5:0] nb_q, nb_d;
	logic [5:0] last_q, last_d;
	logic [FRAME_BITS-1:0] tx_q, tx_d;
	logic [BYTE_BITS-1:0] rx_q, rx_d;
	logic rd_q, rd_d;
	logic cs_n_q, cs_n_d, sclk_q, sclk_d;
	logic rdy_d, vld_d;
	logic [2:0] do_s_q;
	logic do_f_q;
	logic div_end;

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign link.din = tx_q[FRAME_BITS-1];
	assign div_end = (div_q == 8'(HALF - 1));

	// dout filter: level taken once second and third stages agree
	always_ff @(posedge clk) begin
		if (srst) begin
			do_s_q <= '0;
			do_f_q <= 1'b0;
		end else begin
			do_s_q <= {do_s_q[1:0], link.dout};
			do_f_q <= (do_s_q[1] == do_s_q[2]) ? do_s_q[2] : do_f_q;
		end
	end

	// framer next state
	always_comb begin
		logic [ADDR_BITS-1:0] a;
		a = req_addr;
		if (req_read && a[5:3] == MODE_BLK) begin
			a[CHAN_BITS-1:0] = '0; // RULE_10
		end
		st_d = st_q;
		div_d = div_end ? 8'h00 : div_q + 8'h01;
		nb_d = nb_q;
		last_d = last_q;
		tx_d = tx_q;
		rx_d = rx_q;
		rd_d = rd_q;
		cs_n_d = cs_n_q;
		sclk_d = sclk_q;
		vld_d = 1'b0;
		case (st_q)
			SRCF_IDLE: begin
				div_d = '0;
				nb_d = '0;
				if (resync_req) begin
					tx_d = '1; // RULE_04
					last_d = 6'(RESYNC_ONES - 1);
					rd_d = 1'b0;
					cs_n_d = 1'b0;
					st_d = SRCF_LOW;
				end else if (req_valid) begin
					// command first, bit 7 clear, then data (zeros on read)
					tx_d = {1'b0, req_read, a, req_read ? 8'h00 : req_wdata}; // RULE_01 RULE_06 RULE_07
					last_d = 6'(FRAME_BITS - 1);
					rd_d = req_read;
					cs_n_d = 1'b0;
					st_d = SRCF_LOW;
				end
			end
			SRCF_LOW: begin
				if (div_end) begin
					if (rd_q && nb_q >= 6'(BYTE_BITS)) begin
						rx_d = {rx_q[BYTE_BITS-2:0], do_f_q};
					end
					sclk_d = 1'b1;
					st_d = SRCF_HIGH;
				end
			end
			SRCF_HIGH: begin
				if (div_end) begin
					sclk_d = 1'b0;
					if (nb_q == last_q) begin
						st_d = SRCF_END;
					end else begin
						nb_d = nb_q + 6'h01;
						// a resync frame is twice the shifter, so refill with ones
						tx_d = {tx_q[FRAME_BITS-2:0], (last_q == 6'(RESYNC_ONES - 1))}; // RULE_04
						st_d = SRCF_LOW;
					end
				end
			end
			SRCF_END: begin
				if (div_end) begin
					cs_n_d = 1'b1;
					tx_d = '0;
					vld_d = 1'b1;
					st_d = SRCF_IDLE;
				end
			end
			default: begin
				st_d = SRCF_IDLE;
			end
		endcase
		rdy_d = (st_d == SRCF_IDLE);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= SRCF_IDLE;
			div_q <= '0;
			nb_q <= '0;
			last_q <= '0;
			tx_q <= '0;
			rx_q <= '0;
			rd_q <= 1'b0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			req_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			nb_q <= nb_d;
			last_q <= last_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			rd_q <= rd_d;
			cs_n_q <= cs_n_d;
			sclk_q <= sclk_d;
			req_ready <= rdy_d;
			rsp_valid <= vld_d;
			rsp_rdata <= vld_d ? rx_q : rsp_rdata;
		end
	end
endmodule : srcf_host

/* verilog/srcf_link_if.sv */
// four-wire serial link between host framer and command front end
// assumes the host makes sclk; dout is driven by the device only
`timescale 1ns/10ps
interface srcf_link_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	modport dev (input cs_n, input sclk, input din, output dout);
	modport host (output cs_n, output sclk, output din, input dout);
endinterface : srcf_link_if

/* verilog/srcf_pkg.sv */
// constants shared by both ends of the serial register command link
// assumes one command byte then one 8-bit data byte per frame
package srcf_pkg;
	localparam int BYTE_BITS = 8;
	localparam int ADDR_BITS = 6;
	localparam int CHAN_BITS = 3;
	localparam int CHANS = 8;
	// command byte fields
	localparam int CMD_ZERO_BIT = 7;
	localparam int CMD_RD_BIT = 6;
	localparam logic [ADDR_BITS-1:0] CMD_REG_ADDR = 6'h00;
	// register blocks, selected by address bits 5..3
	localparam logic [2:0] SETUP_BLK = 3'h5;
	localparam logic [2:0] MODE_BLK = 3'h7;
	localparam logic [BYTE_BITS-1:0] SETUP_RESET = 8'h00;
	localparam logic [BYTE_BITS-1:0] MODE_RESET = 8'h00;
	// setup bit that selects differential inputs
	localparam int DIFF_BIT = 5;
	// link framing
	localparam int RESYNC_ONES = 32;
	localparam int FRAME_BITS = 16;
	localparam int RST_HOLD = 4;
	// link state machine, gray along cmd -> write / cmd -> read
	typedef enum logic [1:0] {
		SRCF_CMD = 2'h0,
		SRCF_WR = 2'h1,
		SRCF_RD = 2'h2
	} srcf_lst_e;
	// host framer states, gray around the loop
	typedef enum logic [1:0] {
		SRCF_IDLE = 2'h0,
		SRCF_LOW = 2'h1,
		SRCF_HIGH = 2'h3,
		SRCF_END = 2'h2
	} srcf_hst_e;
endpackage : srcf_pkg
